/* rtl/tlic_two_level_irq_ctrl.v */
`timescale 1ns/100ps
`default_nettype none
`include "tlic_consts.vh"

module tlic_two_level_irq_ctrl
(
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Classic source flags, index = interrupt number 0..5
    input wire external0_flag,
    input wire timer0_overflow_flag,
    input wire external1_flag,
    input wire timer1_overflow_flag,
    input wire serial_rx_or_tx_flag,
    input wire timer2_overflow_flag,
    // Added source flags
    input wire external_mem_error_flag,
    input wire extra_serial1_irq,
    input wire internal_mem_error_flag,
    input wire extra_serial2_irq,
    input wire external2_flag,
    input wire extra_serial3_irq,
    input wire external3_flag,
    input wire extra_serial4_irq,
    input wire external4_flag,
    // Classic enables from the core
    input wire global_interrupt_enable,
    input wire [5:0] classicEnable,
    input wire [5:0] classicHighPrio,
    // Core sequencer
    input wire longCallTaken,
    input wire returnFromInterrupt,
    output reg longCallRequest,
    output reg [15:0] longCallAddress,
    output reg [3:0] serviceNumber,
    output reg highInProcess,
    output reg lowInProcess,
    // Special function register port
    input wire [7:0] sfrAddr,
    input wire [7:0] sfrWriteData,
    input wire sfrWrite,
    output reg [7:0] sfrReadData
);

    // -------------------------------------------------------------------
    // Enable fields
    // -------------------------------------------------------------------
    reg [1:0] fieldInMem;
    reg [1:0] fieldExMem;
    reg [1:0] fieldSer1;
    reg [1:0] fieldSer2;
    reg [1:0] fieldSer3;
    reg [1:0] fieldSer4;
    reg [1:0] fieldExt2;
    reg [1:0] fieldExt3;
    reg [1:0] fieldExt4;

    // Command decode: 00 keeps the old setting
    function [1:0] applyCmd;
        input [1:0] old;
        input [1:0] cmd;
        begin
            if (cmd == `TLIC_CMD_NOCHG)
                applyCmd = old;
            else if (cmd == `TLIC_CMD_DIS)
                applyCmd = `TLIC_CMD_DIS;
            else
                applyCmd = cmd;
        end
    endfunction

    // Status: disabled reads with upper bit clear
    function [1:0] status;
        input [1:0] f;
        begin
            status = f[1] ? f : 2'h0;
        end
    endfunction

    wire wrMem = sfrWrite && (sfrAddr == `TLIC_ADDR_MEM_ERR_EN);
    wire wrSer = sfrWrite && (sfrAddr == `TLIC_ADDR_XSER_EN);
    wire wrExt = sfrWrite && (sfrAddr == `TLIC_ADDR_XEXT_EN);

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fieldInMem <= `TLIC_FIELD_RESET;
            fieldExMem <= `TLIC_FIELD_RESET;
            fieldSer1 <= `TLIC_FIELD_RESET;
            fieldSer2 <= `TLIC_FIELD_RESET;
            fieldSer3 <= `TLIC_FIELD_RESET;
            fieldSer4 <= `TLIC_FIELD_RESET;
            fieldExt2 <= `TLIC_FIELD_RESET;
            fieldExt3 <= `TLIC_FIELD_RESET;
            fieldExt4 <= `TLIC_FIELD_RESET;
        end
        else
        begin
            if (wrMem)
            begin
                fieldInMem <= applyCmd(fieldInMem, sfrWriteData[1:0]);
                fieldExMem <= applyCmd(fieldExMem, sfrWriteData[3:2]);
            end
            if (wrSer)
            begin
                fieldSer1 <= applyCmd(fieldSer1, sfrWriteData[7:6]);
                fieldSer2 <= applyCmd(fieldSer2, sfrWriteData[5:4]);
                fieldSer3 <= applyCmd(fieldSer3, sfrWriteData[3:2]);
                fieldSer4 <= applyCmd(fieldSer4, sfrWriteData[1:0]);
            end
            if (wrExt)
            begin
                fieldExt2 <= applyCmd(fieldExt2, sfrWriteData[1:0]);
                fieldExt3 <= applyCmd(fieldExt3, sfrWriteData[3:2]);
                fieldExt4 <= applyCmd(fieldExt4, sfrWriteData[5:4]);
            end
        end
    end

    // -------------------------------------------------------------------
    // Register read
    // -------------------------------------------------------------------
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            sfrReadData <= 8'h00;
        else
        begin
            case (sfrAddr)
                `TLIC_ADDR_MEM_ERR_EN:
                    sfrReadData <= {4'h0, status(fieldExMem),
                        status(fieldInMem)};
                `TLIC_ADDR_XSER_EN:
                    sfrReadData <= {status(fieldSer1), status(fieldSer2),
                        status(fieldSer3), status(fieldSer4)};
                `TLIC_ADDR_XEXT_EN:
                    sfrReadData <= {2'h0, status(fieldExt4),
                        status(fieldExt3), status(fieldExt2)};
                default:
                    sfrReadData <= 8'h00;
            endcase
        end
    end

    // -------------------------------------------------------------------
    // Source vector in interrupt-number order
    // -------------------------------------------------------------------
    wire [14:0] pending = {external4_flag, extra_serial4_irq,
        external3_flag, extra_serial3_irq, external2_flag,
        extra_serial2_irq, internal_mem_error_flag, extra_serial1_irq,
        external_mem_error_flag, timer2_overflow_flag,
        serial_rx_or_tx_flag, timer1_overflow_flag, external1_flag,
        timer0_overflow_flag, external0_flag};

    wire [14:0] srcEnable = {fieldExt4[1], fieldSer4[1], fieldExt3[1],
        fieldSer3[1], fieldExt2[1], fieldSer2[1], fieldInMem[1],
        fieldSer1[1], fieldExMem[1], classicEnable};
    wire [14:0] srcHigh = {fieldExt4[0], fieldSer4[0], fieldExt3[0],
        fieldSer3[0], fieldExt2[0], fieldSer2[0], fieldInMem[0],
        fieldSer1[0], fieldExMem[0], classicHighPrio};

    wire [14:0] highReq = pending & srcEnable & srcHigh;
    wire [14:0] lowReq = pending & srcEnable & ~srcHigh;

    // Lowest set bit wins
    function [3:0] firstSet;
        input [14:0] v;
        integer i;
        begin
            firstSet = 4'h0;
            for (i = `TLIC_NUM_SRC - 1; i >= 0; i = i - 1)
                if (v[i])
                    firstSet = i[3:0];
        end
    endfunction

    // -------------------------------------------------------------------
    // Arbitration
    // -------------------------------------------------------------------
    reg takeHigh;
    reg takeLow;
    reg [3:0] next_number;

    always @*
    begin
        takeHigh = 1'b0;
        takeLow = 1'b0;
        next_number = 4'h0;
        if (!global_interrupt_enable || longCallRequest)
            takeHigh = 1'b0;
        else if (highInProcess)
            takeHigh = 1'b0;
        else if (|highReq)
        begin
            takeHigh = 1'b1;
            next_number = firstSet(highReq);
        end
        else if (lowInProcess)
            takeLow = 1'b0;
        else if (|lowReq)
        begin
            takeLow = 1'b1;
            next_number = firstSet(lowReq);
        end
    end

    // -------------------------------------------------------------------
    // Service and in-process tracking
    // -------------------------------------------------------------------
    reg pendingIsHigh;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            longCallRequest <= 1'b0;
            longCallAddress <= 16'h0000;
            serviceNumber <= 4'h0;
            highInProcess <= 1'b0;
            lowInProcess <= 1'b0;
            pendingIsHigh <= 1'b0;
        end
        else
        begin
            if (longCallRequest && longCallTaken)
            begin
                longCallRequest <= 1'b0;
                if (pendingIsHigh)
                    highInProcess <= 1'b1;
                else
                    lowInProcess <= 1'b1;
            end
            else if (returnFromInterrupt)
            begin
                if (highInProcess)
                    highInProcess <= 1'b0;
                else
                    lowInProcess <= 1'b0;
            end
            if (takeHigh || takeLow)
            begin
                longCallRequest <= 1'b1;
                pendingIsHigh <= takeHigh;
                serviceNumber <= next_number;
                longCallAddress <= {9'h000, next_number, 3'h0}
                    + `TLIC_VEC_OFFSET;
            end
        end
    end

endmodule

`default_nettype wire

/* rtl/tlic_consts.vh */
`ifndef TLIC_CONSTS_VH
`define TLIC_CONSTS_VH

// -----------------------------------------------------------------------
// Register map
// -----------------------------------------------------------------------
`define TLIC_ADDR_MEM_ERR_EN 8'hac
`define TLIC_ADDR_XSER_EN 8'had
`define TLIC_ADDR_XEXT_EN 8'hae

// -----------------------------------------------------------------------
// Field commands and status
// -----------------------------------------------------------------------
`define TLIC_CMD_NOCHG 2'h0
`define TLIC_CMD_DIS 2'h1
`define TLIC_CMD_LOW 2'h2
`define TLIC_CMD_HIGH 2'h3
`define TLIC_FIELD_RESET 2'h0

// -----------------------------------------------------------------------
// Sources and vectors
// -----------------------------------------------------------------------
`define TLIC_NUM_SRC 15
`define TLIC_NUM_CLASSIC 6
`define TLIC_VEC_MULT 8
`define TLIC_VEC_OFFSET 16'h0003

`endif

/* verification/tlic_irq_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module tlic_irq_sva
(
    // Core side
    input wire logic clk,
    input wire logic rst_n,
    input wire logic global_interrupt_enable,
    input wire logic longCallTaken,
    input wire logic returnFromInterrupt,
    input wire logic longCallRequest,
    input wire logic [15:0] longCallAddress,
    input wire logic [3:0] serviceNumber,
    input wire logic highInProcess,
    input wire logic lowInProcess
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence wait_s;
        longCallRequest && !longCallTaken;
    endsequence
    sequence accept_s;
        longCallRequest && longCallTaken;
    endsequence
    sequence ret_s;
        returnFromInterrupt && !longCallTaken;
    endsequence
    hold_req_a: assert property (wait_s |=>
        longCallRequest && $stable(longCallAddress)) else $error("req lost");
    call_addr_a: assert property (longCallRequest |->
        longCallAddress == {9'h0, serviceNumber, 3'h3}) else $error("addr");
    num_range_a: assert property (longCallRequest |->
        serviceNumber <= 4'he) else $error("number");
    gie_gate_a: assert property ($rose(longCallRequest) |->
        $past(global_interrupt_enable)) else $error("gie off");
    high_block_a: assert property ($rose(longCallRequest) |->
        !$past(highInProcess)) else $error("high busy");
    accept_set_a: assert property (accept_s |=>
        !longCallRequest && (highInProcess || lowInProcess)) else $error("acc");
    ret_high_a: assert property (ret_s ##0 highInProcess |=>
        !highInProcess && $stable(lowInProcess)) else $error("ret high");
    ret_low_a: assert property (ret_s ##0 !highInProcess |=>
        !lowInProcess) else $error("ret low");
endmodule
bind tlic_two_level_irq_ctrl tlic_irq_sva chk (.clk(clk), .rst_n(rst_n),
    .global_interrupt_enable(global_interrupt_enable),
    .longCallTaken(longCallTaken), .returnFromInterrupt(returnFromInterrupt),
    .longCallRequest(longCallRequest), .longCallAddress(longCallAddress),
    .serviceNumber(serviceNumber), .highInProcess(highInProcess),
    .lowInProcess(lowInProcess));
`default_nettype wire

/* verification/tlic_core_model.sv */
`timescale 1ns/100ps
`default_nettype none
module tlic_core_model
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Call handshake
    input wire logic [1:0] delay,
    input wire logic longCallRequest,
    output logic longCallTaken
);
    logic [1:0] cnt;
    // Accepts a pending call after delay idle cycles
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt <= 2'h0;
            longCallTaken <= 1'b0;
        end
        else if (longCallRequest && !longCallTaken && cnt != delay)
            cnt <= cnt + 2'h1;
        else
        begin
            cnt <= 2'h0;
            longCallTaken <= longCallRequest && !longCallTaken;
        end
    end
endmodule
`default_nettype wire

/* verification/tlic_two_level_irq_ctrl_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module tlic_two_level_irq_ctrl_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [14:0] fl = 15'h0;
    logic gie = 1'b0;
    logic [5:0] hp = 6'h0;
    logic [5:0] ce = 6'h3f;
    logic [1:0] dly = 2'h3;
    logic ret = 1'b0;
    logic sW = 1'b0;
    logic [7:0] sA = 8'h0;
    logic [7:0] sD = 8'h0;
    wire logic tak, req, hi, lo;
    wire logic [15:0] adr;
    wire logic [3:0] num;
    wire logic [7:0] rdD;
    int bad_count = 0;
    int tests_run = 0;
    always #20 clk = ~clk;
    tlic_core_model core (.clk(clk), .rst_n(rst_n), .delay(dly),
        .longCallRequest(req), .longCallTaken(tak));
    tlic_two_level_irq_ctrl dut (.clk(clk), .rst_n(rst_n),
        .external0_flag(fl[0]), .timer0_overflow_flag(fl[1]),
        .external1_flag(fl[2]), .timer1_overflow_flag(fl[3]),
        .serial_rx_or_tx_flag(fl[4]), .timer2_overflow_flag(fl[5]),
        .external_mem_error_flag(fl[6]), .extra_serial1_irq(fl[7]),
        .internal_mem_error_flag(fl[8]), .extra_serial2_irq(fl[9]),
        .external2_flag(fl[10]), .extra_serial3_irq(fl[11]),
        .external3_flag(fl[12]), .extra_serial4_irq(fl[13]),
        .external4_flag(fl[14]), .global_interrupt_enable(gie),
        .classicEnable(ce), .classicHighPrio(hp), .longCallTaken(tak),
        .returnFromInterrupt(ret), .longCallRequest(req),
        .longCallAddress(adr), .serviceNumber(num), .highInProcess(hi),
        .lowInProcess(lo), .sfrAddr(sA), .sfrWriteData(sD),
        .sfrWrite(sW), .sfrReadData(rdD));
    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sA <= a;
        sD <= d;
        sW <= 1'b1;
        @(posedge clk);
        sW <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        sA <= a;
        repeat (2) @(posedge clk);
        #1 chk({8'h0, rdD}, {8'h0, e});
    endtask
    task automatic waitReq(input logic v);
        int i;
        i = 0;
        while (req !== v && i <= 20)
        begin
            @(posedge clk);
            #1 i++;
        end
        if (i > 20)
        begin
            bad_count++;
            end_sim;
        end
    endtask
    task automatic svc(input logic [3:0] n);
        waitReq(1'b1);
        chk(adr, {9'h0, n, 3'h3});
        chk({12'h0, num}, {12'h0, n});
        waitReq(1'b0);
        @(posedge clk);
        fl[n] <= 1'b0;
    endtask
    task automatic rt(input logic h, input logic l);
        @(posedge clk);
        ret <= 1'b1;
        @(posedge clk);
        ret <= 1'b0;
        #1 chk({14'h0, hi, lo}, {14'h0, h, l});
    endtask
    task automatic idle;
        repeat (6)
        begin
            @(posedge clk);
            #1 chk({15'h0, req}, 16'h0);
        end
    endtask
    task automatic regTest;
        rd(8'hac, 8'h00);
        wr(8'hae, 8'h1b);
        rd(8'hae, 8'h0b);
        wr(8'hae, 8'h00);
        rd(8'hae, 8'h0b);
        wr(8'hae, 8'h01);
        rd(8'hae, 8'h08);
        wr(8'hae, 8'h03);
        rd(8'hae, 8'h0b);
        wr(8'had, 8'hc0);
        rd(8'had, 8'hc0);
        wr(8'hac, 8'hff);
        rd(8'hac, 8'h0f);
        rd(8'h55, 8'h00);
        $display("regTest done");
    endtask
    task automatic orderTest;
        @(posedge clk);
        gie <= 1'b1;
        fl <= 15'h000a;
        svc(4'h1);
        idle;
        fl[10] <= 1'b1;
        fl[0] <= 1'b1;
        svc(4'ha);
        idle;
        rt(1'b0, 1'b1);
        rt(1'b0, 1'b0);
        svc(4'h0);
        rt(1'b0, 1'b0);
        dly <= 2'h0;
        fl <= 15'h0148;
        svc(4'h6);
        rt(1'b0, 1'b0);
        svc(4'h8);
        rt(1'b0, 1'b0);
        svc(4'h3);
        rt(1'b0, 1'b0);
        $display("orderTest done");
    endtask
    task automatic gateTest;
        @(posedge clk);
        gie <= 1'b0;
        hp <= 6'h20;
        fl[5] <= 1'b1;
        idle;
        ce <= 6'h1f;
        gie <= 1'b1;
        idle;
        ce <= 6'h3f;
        svc(4'h5);
        rt(1'b0, 1'b0);
        $display("gateTest done");
    endtask
    task automatic resetTest;
        @(posedge clk);
        fl[0] <= 1'b1;
        svc(4'h0);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1 chk({14'h0, hi, lo}, 16'h0);
        rd(8'had, 8'h00);
        rd(8'hac, 8'h00);
        $display("resetTest done");
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        regTest;
        orderTest;
        gateTest;
        resetTest;
        end_sim;
    end
endmodule
`default_nettype wire
